// ==== src/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned CODE_W = 10;
  localparam int unsigned RES_W = 16;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned TICK_W = 4;
  localparam int unsigned CLOCK_DIVIDER_SELECT_W = 3;
  localparam int unsigned REFERENCE_SOURCE_W = 2;
  localparam int unsigned ACC_W = 3;
  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MAIN = 6'h00;
  localparam logic [IDX_W-1:0] IDX_ACC = 6'h01;
  localparam logic [IDX_W-1:0] IDX_REF = 6'h02;
  localparam logic [IDX_W-1:0] IDX_DELAY = 6'h03;
  localparam logic [IDX_W-1:0] IDX_WINMODE = 6'h04;
  localparam logic [IDX_W-1:0] IDX_SAMPLEN = 6'h05;
  localparam logic [IDX_W-1:0] IDX_CHANNEL = 6'h06;
  localparam logic [IDX_W-1:0] IDX_CMD = 6'h08;
  localparam logic [IDX_W-1:0] IDX_EVIN = 6'h09;
  localparam logic [IDX_W-1:0] IDX_INT_EN = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_DEBUG = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_SCRATCH = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_RESULT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_WIN_LO = 6'h12;
  localparam logic [IDX_W-1:0] IDX_WIN_HI = 6'h14;
  localparam logic [IDX_W-1:0] IDX_DUTY_CYCLE_CALIBRATION = 6'h16;
  // field layout
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned CONTINUOUS_CONVERSION_BIT = 1;
  localparam int unsigned RESOLUTION_SELECT_BIT = 2;
  localparam int unsigned STANDBY_RUN_BIT = 7;
  localparam int unsigned SAMPLE_CAPACITOR_SIZE_BIT = 6;
  localparam int unsigned REFERENCE_SOURCE_LSB = 4;
  localparam int unsigned CLOCK_DIVIDER_SELECT_LSB = 0;
  localparam int unsigned ACC_LSB = 0;
  localparam int unsigned CONVERSION_TRIGGER_BIT = 0;
  localparam int unsigned RESULT_READY_FLAG_BIT = 0;
  localparam logic [7:0] MAIN_MASK = 8'h87;
  localparam logic [7:0] ACC_MASK = 8'h07;
  localparam logic [7:0] REF_MASK = 8'h77;
  localparam logic [1:0] INT_EN_MASK = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] ACC_RESERVED = 3'h7;
  // last converter tick index of a sample; a sample takes 13 converter clocks
  localparam logic [TICK_W-1:0] CONV_LAST = 4'hc;

  function automatic logic [DIV_W-1:0] div_last(input logic [CLOCK_DIVIDER_SELECT_W-1:0] clock_divider_select);
    div_last = DIV_W'((16'h0002 << clock_divider_select) - 16'h0001);
  endfunction

  function automatic logic [CNT_W-1:0] acc_last(input logic [ACC_W-1:0] code);
    if (code == ACC_RESERVED) begin
      acc_last = '0;
    end else begin
      acc_last = CNT_W'((8'h01 << code) - 8'h01);
    end
  endfunction

  function automatic logic [RES_W-1:0] fit_sample(input logic [CODE_W-1:0] code,
                                                  input logic low_res);
    if (low_res) begin
      fit_sample = {8'h00, code[CODE_W-1:2]};
    end else begin
      fit_sample = {6'h00, code};
    end
  endfunction
endpackage

// ==== src/conv_if.sv ====
`timescale 1ns/1ps
interface conv_if;
  logic run;
  logic [adc_ctrl_pkg::CLOCK_DIVIDER_SELECT_W-1:0] clock_divider_select;
  logic tick;
  logic clk_adc;
  logic start;
  logic abort;
  logic busy;
  logic done;
  logic [adc_ctrl_pkg::CODE_W-1:0] data;
  modport ctl(output run, clock_divider_select, start, abort, input tick, clk_adc, busy, done, data);
  modport div(input run, clock_divider_select, output tick, clk_adc);
  modport core(input tick, start, abort, output busy, done, data);
endinterface

// ==== src/clock_divider.sv ====
`timescale 1ns/1ps
module clock_divider (
  input wire logic mclk,
  input wire logic srst,
  conv_if.div cif
);
  import adc_ctrl_pkg::*;

  logic [DIV_W-1:0] count_q;
  logic clk_q;
  logic [DIV_W-1:0] last_w;
  logic [DIV_W-1:0] gap_q;
  logic seen_q;

  assign last_w = div_last(cif.clock_divider_select);
  assign cif.tick = cif.run && (count_q == last_w);
  assign cif.clk_adc = clk_q;

  // >= recovers cleanly when the divider shrinks mid-count
  always_ff @(posedge mclk) begin
    if (srst || !cif.run || count_q >= last_w) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !cif.run) begin
      clk_q <= 1'b0;
    end else if (count_q == last_w) begin
      clk_q <= 1'b0;
    end else if (count_q == (last_w >> 1)) begin
      clk_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (srst || !cif.run || cif.tick || !$stable(cif.clock_divider_select)) begin
      gap_q <= '0;
      seen_q <= cif.tick && cif.run && !srst;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  tick_spacing_a: assert property (@(posedge mclk) disable iff (srst)
    cif.tick && seen_q && $stable(cif.clock_divider_select) |-> gap_q == last_w)
    else $error("converter tick spacing wrong");
endmodule

// ==== src/sar_core.sv ====
`timescale 1ns/1ps
module sar_core (
  input wire logic mclk,
  input wire logic srst,
  conv_if.core cif,
  input wire logic [adc_ctrl_pkg::CODE_W-1:0] analog_code
);
  import adc_ctrl_pkg::*;

  logic busy_q;
  logic done_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [CODE_W-1:0] data_q;
  logic last_w;

  assign last_w = busy_q && cif.tick && (tick_cnt_q == CONV_LAST);
  assign cif.busy = busy_q;
  assign cif.done = done_q;
  assign cif.data = data_q;

  always_ff @(posedge mclk) begin
    if (srst || cif.abort) begin
      busy_q <= 1'b0;
    end else if (cif.start) begin
      busy_q <= 1'b1;
    end else if (last_w) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cif.start) begin
      tick_cnt_q <= '0;
    end else if (busy_q && cif.tick) begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // analog code is taken as settled on the last converter tick
  always_ff @(posedge mclk) begin
    if (srst) begin
      done_q <= 1'b0;
      data_q <= '0;
    end else begin
      done_q <= last_w && !cif.abort;
      if (last_w) begin
        data_q <= analog_code;
      end
    end
  end
endmodule

// ==== src/adc_control_registers.sv ====
`timescale 1ns/1ps
module adc_control_registers (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic [adc_ctrl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic standby_sleep,
  input wire logic [adc_ctrl_pkg::CODE_W-1:0] analog_code,
  output logic adc_clk,
  output logic converter_enable,
  output logic sample_capacitor_size,
  output logic [adc_ctrl_pkg::REFERENCE_SOURCE_W-1:0] reference_source
);
  import adc_ctrl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_RESTART} conv_state_e;

  logic [7:0] main_q;
  logic [7:0] acc_ctl_q;
  logic [7:0] ref_q;
  logic [1:0] int_en_q;
  logic ready_flag_q;
  logic conversion_trigger_q;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] sum_q;
  logic [CNT_W-1:0] cnt_q;
  logic start_q;
  conv_state_e state_q;
  logic irq_q;
  logic pready_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rd_d;

  logic [IDX_W-1:0] idx;
  logic aligned;
  logic rd_setup;
  logic wr_acc;
  logic wr_main;
  logic enabled;
  logic continuous_conversion_on;
  logic active;
  logic cmd_set;
  logic final_w;
  logic [RES_W-1:0] sample_w;

  conv_if cif();

  clock_divider u_div (
    .mclk(mclk),
    .srst(srst),
    .cif(cif.div)
  );

  sar_core u_core (
    .mclk(mclk),
    .srst(srst),
    .cif(cif.core),
    .analog_code(analog_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state on every access
  // a write lands on the edge that also shows pready high
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign rd_setup = psel && penable && !pready_q;
  assign wr_acc = psel && penable && pwrite && pready_q && aligned;
  assign wr_main = wr_acc && (idx == IDX_MAIN);

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= rd_setup;
    end
  end

  always_comb begin
    rd_d = '0;
    if (aligned) begin
      case (idx)
        IDX_MAIN: rd_d[7:0] = main_q;
        IDX_ACC: rd_d[7:0] = acc_ctl_q;
        IDX_REF: rd_d[7:0] = ref_q;
        IDX_CMD: rd_d[CONVERSION_TRIGGER_BIT] = conversion_trigger_q;
        IDX_INT_EN: rd_d[1:0] = int_en_q;
        IDX_FLAGS: rd_d[RESULT_READY_FLAG_BIT] = ready_flag_q;
        IDX_RESULT: rd_d[RES_W-1:0] = result_q;
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= pwrite ? '0 : rd_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  // no access is ever refused, so the error line stays low
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // control registers; reserved bits are masked off on write
  always_ff @(posedge mclk) begin
    if (srst) begin
      main_q <= REG_RESET;
    end else if (wr_main) begin
      main_q <= pwdata[7:0] & MAIN_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_ctl_q <= REG_RESET;
    end else if (wr_acc && idx == IDX_ACC) begin
      // code 7 is kept as written and runs a single sample
      acc_ctl_q <= pwdata[7:0] & ACC_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_q <= REG_RESET;
    end else if (wr_acc && idx == IDX_REF) begin
      ref_q <= pwdata[7:0] & REF_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      int_en_q <= '0;
    end else if (wr_acc && idx == IDX_INT_EN) begin
      int_en_q <= pwdata[1:0] & INT_EN_MASK;
    end
  end

  // reference pins go straight to the analog front end
  assign sample_capacitor_size = ref_q[SAMPLE_CAPACITOR_SIZE_BIT];
  assign reference_source = ref_q[REFERENCE_SOURCE_LSB +: REFERENCE_SOURCE_W];
  assign converter_enable = main_q[ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencing
  assign enabled = main_q[ENABLE_BIT];
  assign continuous_conversion_on = main_q[CONTINUOUS_CONVERSION_BIT];
  // asleep without the run bit the converter freezes, it does not abort
  assign active = enabled && (!standby_sleep || main_q[STANDBY_RUN_BIT]);
  assign cmd_set = wr_acc && (idx == IDX_CMD) && pwdata[CONVERSION_TRIGGER_BIT] && enabled;
  assign sample_w = fit_sample(cif.data, main_q[RESOLUTION_SELECT_BIT]);
  // lowering the sample count mid-run lets the counter wrap before it matches
  assign final_w = cif.done && (cnt_q == acc_last(acc_ctl_q[ACC_LSB +: ACC_W]));

  assign cif.run = active;
  assign cif.clock_divider_select = ref_q[CLOCK_DIVIDER_SELECT_LSB +: CLOCK_DIVIDER_SELECT_W];
  assign cif.start = start_q;
  assign cif.abort = !enabled;
  assign adc_clk = cif.clk_adc;

  always_ff @(posedge mclk) begin
    if (srst || !enabled) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (conversion_trigger_q && active) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (final_w) begin
            state_q <= continuous_conversion_on ? ST_RESTART : ST_IDLE;
          end
        end
        // one cycle here lets the trigger bit rise again on the same edge as the next start
        ST_RESTART: begin
          if (active) begin
            state_q <= ST_CONVERT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !enabled) begin
      start_q <= 1'b0;
    end else begin
      start_q <= (state_q == ST_IDLE && conversion_trigger_q && active)
              || (state_q == ST_RESTART && active)
              || (state_q == ST_CONVERT && cif.done && !final_w);
    end
  end

  // a fresh trigger in the completion cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (srst || !enabled) begin
      conversion_trigger_q <= 1'b0;
    end else if (cmd_set || (state_q == ST_RESTART && active)) begin
      conversion_trigger_q <= 1'b1;
    end else if (final_w) begin
      conversion_trigger_q <= 1'b0;
    end
  end

  // cleared at completion and on abort so the next run sums from zero
  always_ff @(posedge mclk) begin
    if (srst || final_w || !enabled) begin
      cnt_q <= '0;
      sum_q <= '0;
    end else if (cif.done && !final_w) begin
      cnt_q <= cnt_q + 1'b1;
      sum_q <= sum_q + sample_w;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      result_q <= '0;
    end else if (final_w) begin
      result_q <= sum_q + sample_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky ready flag, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_flag_q <= 1'b0;
    end else begin
      ready_flag_q <= final_w
        || (ready_flag_q && !(wr_acc && idx == IDX_FLAGS && pwdata[RESULT_READY_FLAG_BIT]));
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ready_flag_q && int_en_q[RESULT_READY_FLAG_BIT];
    end
  end

  // irq lags the flag by one cycle so the pin stays a flop output
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  sequence conv_done_s;
    final_w && continuous_conversion_on && !wr_main && !srst;
  endsequence

  sequence relaunch_s;
    (state_q == ST_RESTART && active) ##1 (state_q == ST_CONVERT && conversion_trigger_q && start_q);
  endsequence

  continuous_conversion_restart_a: assert property (@(posedge mclk) disable iff (srst)
    conv_done_s ##1 active |-> relaunch_s)
    else $error("continuous mode did not relaunch");

  no_autostart_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == ST_IDLE && !conversion_trigger_q |=> state_q != ST_CONVERT)
    else $error("conversion began without trigger");

  trigger_busy_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == ST_CONVERT |-> conversion_trigger_q)
    else $error("trigger bit low during conversion");

  done_flag_a: assert property (@(posedge mclk) disable iff (srst)
    final_w && !cmd_set && state_q == ST_CONVERT |=> ready_flag_q && !conversion_trigger_q)
    else $error("completion did not flag or clear trigger");

  disable_idle_a: assert property (@(posedge mclk) disable iff (srst)
    !enabled |=> state_q == ST_IDLE && !conversion_trigger_q && !cif.busy)
    else $error("converter ran while disabled");

  full_res_a: assert property (@(posedge mclk) disable iff (srst)
    cif.done && cnt_q == '0 && final_w && !main_q[RESOLUTION_SELECT_BIT]
    |=> result_q == {6'h00, $past(cif.data)})
    else $error("ten bit result wrong");

  trunc_res_a: assert property (@(posedge mclk) disable iff (srst)
    cif.done && cnt_q == '0 && final_w && main_q[RESOLUTION_SELECT_BIT]
    |=> result_q == {8'h00, $past(cif.data[CODE_W-1:2])})
    else $error("eight bit result wrong");

  partial_hold_a: assert property (@(posedge mclk) disable iff (srst)
    cif.done && !final_w |=> $stable(result_q) && !$rose(ready_flag_q))
    else $error("partial accumulation published");

  standby_hold_a: assert property (@(posedge mclk) disable iff (srst)
    enabled && standby_sleep && !main_q[STANDBY_RUN_BIT] && !wr_main && !cif.done
    |=> $stable(state_q) && !cif.tick)
    else $error("converter moved in standby");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (srst)
    rd_setup && !pwrite && (!aligned || idx == IDX_DELAY || idx == IDX_DUTY_CYCLE_CALIBRATION)
    |=> pready_q && prdata_q == '0)
    else $error("unmapped read not zero");

  irq_level_a: assert property (@(posedge mclk) disable iff (srst)
    ready_flag_q && int_en_q[RESULT_READY_FLAG_BIT] |=> irq_q)
    else $error("interrupt missing");

  irq_clear_a: assert property (@(posedge mclk) disable iff (srst)
    !(ready_flag_q && int_en_q[RESULT_READY_FLAG_BIT]) |=> !irq_q)
    else $error("interrupt stuck high");

  sequence cmd_taken_s;
    cmd_set ##1 (state_q == ST_IDLE && active);
  endsequence

  trigger_start_a: assert property (@(posedge mclk) disable iff (srst)
    cmd_taken_s |=> state_q == ST_CONVERT && start_q)
    else $error("trigger did not start conversion");

  result_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !final_w |=> $stable(result_q))
    else $error("result changed outside completion");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import adc_ctrl_pkg::*;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, irq, standby_sleep;
  logic adc_clk, converter_enable, sample_capacitor_size;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [CODE_W-1:0] analog_code;
  logic [REFERENCE_SOURCE_W-1:0] reference_source;
  int n_mismatch = 0;
  int n_checks = 0;

  adc_control_registers dut (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .standby_sleep(standby_sleep),
    .analog_code(analog_code), .adc_clk(adc_clk), .converter_enable(converter_enable),
    .sample_capacitor_size(sample_capacitor_size), .reference_source(reference_source)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [7:0] ba(input logic [IDX_W-1:0] i);
    ba = {i, 2'b00};
  endfunction

  // entered just after a rising edge; one idle edge after release keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    chk(nm, exp, x);
  endtask

  task automatic wait_flag();
    logic [31:0] d;
    int n;
    n = 0;
    d = '0;
    while (d[RESULT_READY_FLAG_BIT] !== 1'b1 && n < 2000) begin
      apb(1'b0, ba(IDX_FLAGS), 32'h0, d);
      n++;
    end
    chk("ready flag", 32'h1, {31'h0, d[RESULT_READY_FLAG_BIT]});
  endtask

  // mclk cycles between two rising edges of the converter clock
  task automatic period(output int p);
    int n;
    n = 0;
    p = 0;
    while (adc_clk !== 1'b0 && n < 600) begin @(posedge mclk); n++; end
    while (adc_clk !== 1'b1 && n < 600) begin @(posedge mclk); n++; end
    while (adc_clk !== 1'b0 && p < 600) begin @(posedge mclk); p++; end
    while (adc_clk !== 1'b1 && p < 600) begin @(posedge mclk); p++; end
  endtask

  task automatic conv(input logic [7:0] mainv, input logic [2:0] acc,
                      input logic [2:0] clock_divider_select, input logic [9:0] code, input logic ien);
    int p;
    int n;
    logic [15:0] e;
    n = (acc == 3'h7) ? 1 : (1 << acc);
    e = 16'(n * (mainv[RESOLUTION_SELECT_BIT] ? int'(code[9:2]) : int'(code)));
    analog_code <= code;
    wr(ba(IDX_MAIN), {24'h0, mainv});
    wr(ba(IDX_ACC), {29'h0, acc});
    wr(ba(IDX_REF), {29'h0, clock_divider_select});
    wr(ba(IDX_INT_EN), {31'h0, ien});
    wr(ba(IDX_CMD), 32'h1);
    rd_chk("trigger busy", ba(IDX_CMD), 32'h1);
    period(p);
    chk("adc_clk period", 32'h2 << clock_divider_select, 32'(p));
    wait_flag();
    rd_chk("trigger done", ba(IDX_CMD), 32'h0);
    rd_chk("result", ba(IDX_RESULT), {16'h0, e});
    repeat (2) @(posedge mclk);
    chk("irq level", {31'h0, ien}, {31'h0, irq});
    wr(ba(IDX_FLAGS), 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // generous bound: the longest conversions run a few thousand cycles each
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    logic [IDX_W-1:0] rst_idx [7];
    rst_idx = '{IDX_MAIN, IDX_ACC, IDX_REF, IDX_CMD, IDX_INT_EN, IDX_FLAGS, IDX_RESULT};
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    standby_sleep = 1'b0;
    analog_code = '0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    foreach (rst_idx[i]) rd_chk("reset value", ba(rst_idx[i]), 32'h0);
    chk("adc_clk idle", 32'h0, {31'h0, adc_clk});
    // enable plus continuous alone must not start anything
    wr(ba(IDX_MAIN), 32'hff);
    rd_chk("main mask", ba(IDX_MAIN), 32'h87);
    chk("converter_enable on", 32'h1, {31'h0, converter_enable});
    repeat (100) @(posedge mclk);
    rd_chk("no self start", ba(IDX_CMD), 32'h0);
    rd_chk("no self flag", ba(IDX_FLAGS), 32'h0);
    wr(ba(IDX_MAIN), 32'h0);
    chk("converter_enable off", 32'h0, {31'h0, converter_enable});
    wr(ba(IDX_CMD), 32'h1);
    rd_chk("trigger while off", ba(IDX_CMD), 32'h0);
    wr(ba(IDX_ACC), 32'hfe);
    rd_chk("acc mask", ba(IDX_ACC), 32'h06);
    wr(ba(IDX_REF), 32'hef);
    rd_chk("ref mask", ba(IDX_REF), 32'h67);
    wr(ba(IDX_INT_EN), 32'hff);
    rd_chk("int enable mask", ba(IDX_INT_EN), 32'h3);
    wr(8'h1c, 32'hff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(ba(IDX_DELAY), 32'hff);
    rd_chk("unimplemented", ba(IDX_DELAY), 32'h0);
    rd_chk("unaligned", 8'h01, 32'h0);
    // reference source codes 0 to 2 and both capacitor sizes reach their pins
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 2; c++) begin
        wr(ba(IDX_REF), 32'((c << SAMPLE_CAPACITOR_SIZE_BIT) | (r << REFERENCE_SOURCE_LSB)));
        chk("reference_source", 32'(r), {30'h0, reference_source});
        chk("sample_capacitor_size", 32'(c), {31'h0, sample_capacitor_size});
      end
    end
    for (int p = 0; p < 8; p++) conv(8'h01, 3'h0, 3'(p), 10'h2a5, 1'b1);
    for (int a = 1; a < 8; a++) conv(8'h05, 3'(a), 3'h0, 10'h3ff, 1'b0);
    conv(8'h01, 3'h6, 3'h0, 10'h2a5, 1'b0);
    // continuous: slower divider so the restart is seen before the next completion
    wr(ba(IDX_REF), 32'h2);
    wr(ba(IDX_ACC), 32'h0);
    wr(ba(IDX_MAIN), 32'h3);
    wr(ba(IDX_CMD), 32'h1);
    wait_flag();
    wr(ba(IDX_FLAGS), 32'h1);
    rd_chk("restart", ba(IDX_CMD), 32'h1);
    wait_flag();
    wr(ba(IDX_MAIN), 32'h0);
    rd_chk("abort", ba(IDX_CMD), 32'h0);
    wr(ba(IDX_FLAGS), 32'h1);
    // standby without the run bit freezes, resumes on wake
    wr(ba(IDX_REF), 32'h0);
    wr(ba(IDX_MAIN), 32'h1);
    standby_sleep <= 1'b1;
    wr(ba(IDX_CMD), 32'h1);
    repeat (200) @(posedge mclk);
    rd_chk("frozen flag", ba(IDX_FLAGS), 32'h0);
    rd_chk("frozen trigger", ba(IDX_CMD), 32'h1);
    standby_sleep <= 1'b0;
    wait_flag();
    wr(ba(IDX_FLAGS), 32'h1);
    wr(ba(IDX_MAIN), 32'h81);
    standby_sleep <= 1'b1;
    wr(ba(IDX_CMD), 32'h1);
    wait_flag();
    standby_sleep <= 1'b0;
    wr(ba(IDX_FLAGS), 32'h1);
    rd_chk("flag cleared", ba(IDX_FLAGS), 32'h0);
    tally_and_finish();
  end
endmodule
